// ### design/hss_pkg.sv
// constants, encodings and carrier types for the high-side switch control block
// assumes a single 250 MHz core clock shared by the register port and all logic
package hss_pkg;

   // clock and filter timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int OC_FILTER_NS  = 16000;
   localparam int OC_FILTER_CYC = OC_FILTER_NS / CLK_PERIOD_NS;
   localparam int OC_CNT_W      = 12;
   localparam int OL_FILTER_NS  = 64000;
   localparam int OL_FILTER_CYC = OL_FILTER_NS / CLK_PERIOD_NS;

   // pwm timebase: 256 steps per period at the slow frequency
   localparam int PWM_BASE_HZ  = 200;
   localparam int PWM_STEPS    = 256;
   localparam int PWM_TICK_CYC = 1000000000 / (CLK_PERIOD_NS * PWM_BASE_HZ * PWM_STEPS);

   // register byte offsets
   localparam logic [7:0] OFS_CTRL_A     = 8'h00;
   localparam logic [7:0] OFS_CTRL_B     = 8'h04;
   localparam logic [7:0] OFS_DUTY1      = 8'h08;
   localparam logic [7:0] OFS_DUTY2      = 8'h0c;
   localparam logic [7:0] OFS_FREQ       = 8'h10;
   localparam logic [7:0] OFS_SUPPLY_CFG = 8'h14;
   localparam logic [7:0] OFS_OC_STAT    = 8'h18;
   localparam logic [7:0] OFS_OL_STAT    = 8'h1c;
   localparam logic [7:0] OFS_SUPPLY_ST  = 8'h20;

   // field positions
   localparam int CTRL_FIELD_STRIDE = 4;
   localparam int SUP_OV_DIS_BIT    = 0;
   localparam int SUP_UV_DIS_BIT    = 1;
   localparam int SUP_REC_BIT       = 2;

   // output source codes
   localparam logic [2:0] SRC_OFF    = 3'h0;
   localparam logic [2:0] SRC_ON     = 3'h1;
   localparam logic [2:0] SRC_TIMER1 = 3'h2;
   localparam logic [2:0] SRC_TIMER2 = 3'h3;
   localparam logic [2:0] SRC_PWM1   = 3'h4;
   localparam logic [2:0] SRC_PWM2   = 3'h5;

   // values after reset
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [1:0] FREQ_RESET = 2'h0;

   typedef enum logic [4:0] {
      MODE_NORMAL   = 5'h01,
      MODE_STOP     = 5'h02,
      MODE_SLEEP    = 5'h04,
      MODE_RESTART  = 5'h08,
      MODE_FAILSAFE = 5'h10
   } mode_e;

   typedef struct packed {
      logic       ov;
      logic       uv;
      logic [3:0] oc;
      logic [3:0] ol;
   } sense_s;

endpackage

// ### design/high_side_switch_control.sv
// four high-side switch drivers with pwm generators, supply and load protection
// assumes sbc_mode, timer1 and timer2 come from core_clk logic; sense inputs are asynchronous
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module high_side_switch_control
   import hss_pkg::*;
#(
   parameter int OL_FILTER_CYCLES = OL_FILTER_CYC,
   parameter int PWM_TICK_CYCLES  = PWM_TICK_CYC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // chip mode and timer levels
   input  wire mode_e       sbc_mode,
   input  wire logic        timer1,
   input  wire logic        timer2,
   // analog comparator levels
   input  wire sense_s      sense_async,
   // switch drive
   output logic      [3:0]  high_side_output
);

   localparam int OL_W  = $clog2(OL_FILTER_CYCLES + 1);
   localparam int PRE_W = $clog2(PWM_TICK_CYCLES + 1);

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   function automatic logic cfg_writable(input mode_e m);
      case (m)
         MODE_NORMAL: cfg_writable = 1'b1;
         default:     cfg_writable = 1'b0;
      endcase
   endfunction

   function automatic logic forced_off_mode(input mode_e m);
      case (m)
         MODE_RESTART:  forced_off_mode = 1'b1;
         MODE_FAILSAFE: forced_off_mode = 1'b1;
         default:       forced_off_mode = 1'b0;
      endcase
   endfunction

   function automatic logic source_level(input logic [2:0] src, input logic t1,
                                         input logic t2, input logic [1:0] pwm);
      case (src)
         SRC_ON:     source_level = 1'b1;
         SRC_TIMER1: source_level = t1;
         SRC_TIMER2: source_level = t2;
         SRC_PWM1:   source_level = pwm[0];
         SRC_PWM2:   source_level = pwm[1];
         default:    source_level = 1'b0;
      endcase
   endfunction

   // state
   sense_s     sense_meta;
   sense_s     sense_sync;
   mode_e      prev_mode;
   logic [2:0] cfg [4];
   logic [7:0] duty_gen [2];
   logic [1:0] gen_frequency_select;
   logic       overvolt_shutdown_cfg;
   logic       undervolt_shutdown_cfg;
   logic       supply_fault_recovery_en;
   logic [3:0] output_overcurrent_flag;
   logic [3:0] open_load_flag;
   logic       switch_supply_overvolt_flag;
   logic       switch_supply_undervolt_flag;

   // decode
   logic        cfg_open;
   logic        forced_off;
   logic        entering_forced;
   logic        supply_trip;
   logic        supply_clear;
   logic [1:0]  wr_ctrl;
   logic        wr_duty1;
   logic        wr_duty2;
   logic        wr_freq;
   logic        wr_supply_cfg;
   logic [3:0]  clr_oc;
   logic [3:0]  clr_ol;
   logic [1:0]  clr_supply;
   logic [1:0]  pwm_out;
   logic [3:0]  oc_trip;
   logic [3:0]  ol_trip;
   logic [3:0]  next_output;
   logic [31:0] rd_value;

   // the first stage feeds only the second
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sense_meta <= '0;
         sense_sync <= '0;
      end else begin
         sense_meta <= sense_async;
         sense_sync <= sense_meta;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prev_mode <= MODE_NORMAL;
      end else begin
         prev_mode <= sbc_mode;
      end
   end

   assign cfg_open        = cfg_writable(sbc_mode);
   assign forced_off      = forced_off_mode(sbc_mode);
   assign entering_forced = forced_off & ~forced_off_mode(prev_mode);
   assign supply_trip     = (sense_sync.ov & ~overvolt_shutdown_cfg)
                          | (sense_sync.uv & ~undervolt_shutdown_cfg);
   assign supply_clear    = supply_trip & ~supply_fault_recovery_en;

   assign wr_ctrl[0]    = reg_wr & cfg_open & addr_hit(reg_addr, OFS_CTRL_A);
   assign wr_ctrl[1]    = reg_wr & cfg_open & addr_hit(reg_addr, OFS_CTRL_B);
   assign wr_duty1      = reg_wr & cfg_open & addr_hit(reg_addr, OFS_DUTY1);
   assign wr_duty2      = reg_wr & cfg_open & addr_hit(reg_addr, OFS_DUTY2);
   assign wr_freq       = reg_wr & cfg_open & addr_hit(reg_addr, OFS_FREQ);
   assign wr_supply_cfg = reg_wr & cfg_open & addr_hit(reg_addr, OFS_SUPPLY_CFG);
   assign clr_oc     = (reg_wr & addr_hit(reg_addr, OFS_OC_STAT)) ? reg_wdata[3:0] : 4'h0;
   assign clr_ol     = (reg_wr & addr_hit(reg_addr, OFS_OL_STAT)) ? reg_wdata[3:0] : 4'h0;
   assign clr_supply = (reg_wr & addr_hit(reg_addr, OFS_SUPPLY_ST)) ? reg_wdata[1:0] : 2'h0;

   // hardware clears beat a software write in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            cfg[i] <= SRC_OFF;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (entering_forced | supply_clear | oc_trip[i]) begin
               cfg[i] <= SRC_OFF;
            end else if (wr_ctrl[i / 2]) begin
               cfg[i] <= reg_wdata[(i % 2) * CTRL_FIELD_STRIDE +: 3];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         duty_gen[0]              <= DUTY_RESET;
         duty_gen[1]              <= DUTY_RESET;
         gen_frequency_select     <= FREQ_RESET;
         overvolt_shutdown_cfg    <= 1'b0;
         undervolt_shutdown_cfg   <= 1'b0;
         supply_fault_recovery_en <= 1'b0;
      end else begin
         if (wr_duty1) begin
            duty_gen[0] <= reg_wdata[7:0];
         end
         if (wr_duty2) begin
            duty_gen[1] <= reg_wdata[7:0];
         end
         if (wr_freq) begin
            gen_frequency_select <= reg_wdata[1:0];
         end
         if (wr_supply_cfg) begin
            overvolt_shutdown_cfg    <= reg_wdata[SUP_OV_DIS_BIT];
            undervolt_shutdown_cfg   <= reg_wdata[SUP_UV_DIS_BIT];
            supply_fault_recovery_en <= reg_wdata[SUP_REC_BIT];
         end
      end
   end

   // flags: a set in the clearing cycle survives
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         output_overcurrent_flag      <= 4'h0;
         open_load_flag               <= 4'h0;
         switch_supply_overvolt_flag  <= 1'b0;
         switch_supply_undervolt_flag <= 1'b0;
      end else begin
         output_overcurrent_flag <= oc_trip | (output_overcurrent_flag & ~clr_oc);
         open_load_flag          <= ol_trip | (open_load_flag & ~clr_ol);
         switch_supply_overvolt_flag  <= sense_sync.ov
                                       | (switch_supply_overvolt_flag & ~clr_supply[0]);
         switch_supply_undervolt_flag <= sense_sync.uv
                                       | (switch_supply_undervolt_flag & ~clr_supply[1]);
      end
   end

   // pwm generators; the step counter never stops, so a new assignment starts mid-period
   for (genvar g = 0; g < 2; g++) begin : gen_pwm
      logic [PRE_W-1:0] pre;
      logic [7:0]       step;
      logic [PRE_W-1:0] limit;
      logic             tick;

      assign limit = gen_frequency_select[g] ? PRE_W'(PWM_TICK_CYCLES / 2)
                                             : PRE_W'(PWM_TICK_CYCLES);
      assign tick  = (pre >= limit - PRE_W'(1));

      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            pre  <= '0;
            step <= 8'h00;
         end else begin
            pre  <= tick ? '0 : pre + PRE_W'(1);
            step <= tick ? step + 8'h01 : step;
         end
      end

      assign pwm_out[g] = (step < duty_gen[g]);
   end

   // per-output protection filters, active in every mode
   for (genvar i = 0; i < 4; i++) begin : gen_out
      logic [OC_CNT_W-1:0] oc_cnt;
      logic [OL_W-1:0]     ol_cnt;
      logic                oc_active;
      logic                ol_active;

      assign oc_active  = high_side_output[i] & sense_sync.oc[i];
      assign ol_active  = high_side_output[i] & sense_sync.ol[i];
      assign oc_trip[i] = oc_active & (oc_cnt == OC_CNT_W'(OC_FILTER_CYC - 1));
      assign ol_trip[i] = ol_active & (ol_cnt == OL_W'(OL_FILTER_CYCLES - 1));

      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            oc_cnt <= '0;
            ol_cnt <= '0;
         end else begin
            oc_cnt <= (oc_active & ~oc_trip[i]) ? oc_cnt + OC_CNT_W'(1) : '0;
            ol_cnt <= (ol_active & ~ol_trip[i]) ? ol_cnt + OL_W'(1) : ol_cnt;
            if (!ol_active) begin
               ol_cnt <= '0;
            end
         end
      end

      // with recovery enabled the field is kept, so drive resumes when the fault ends
      assign next_output[i] = source_level(cfg[i], timer1, timer2, pwm_out)
                            & ~forced_off
                            & ~supply_trip
                            & ~oc_trip[i];
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         high_side_output <= 4'h0;
      end else begin
         high_side_output <= next_output;
      end
   end

   // register read path
   assign rd_value =
      addr_hit(reg_addr, OFS_CTRL_A)     ? {25'h0, cfg[1], 1'b0, cfg[0]} :
      addr_hit(reg_addr, OFS_CTRL_B)     ? {25'h0, cfg[3], 1'b0, cfg[2]} :
      addr_hit(reg_addr, OFS_DUTY1)      ? {24'h0, duty_gen[0]} :
      addr_hit(reg_addr, OFS_DUTY2)      ? {24'h0, duty_gen[1]} :
      addr_hit(reg_addr, OFS_FREQ)       ? {30'h0, gen_frequency_select} :
      addr_hit(reg_addr, OFS_SUPPLY_CFG) ? {29'h0, supply_fault_recovery_en,
                                            undervolt_shutdown_cfg, overvolt_shutdown_cfg} :
      addr_hit(reg_addr, OFS_OC_STAT)    ? {28'h0, output_overcurrent_flag} :
      addr_hit(reg_addr, OFS_OL_STAT)    ? {28'h0, open_load_flag} :
      addr_hit(reg_addr, OFS_SUPPLY_ST)  ? {30'h0, switch_supply_undervolt_flag,
                                            switch_supply_overvolt_flag} :
                                           32'h0;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? rd_value : 32'h0;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_forced_off;
      forced_off |=> (high_side_output == 4'h0);
   endproperty
   a_forced_off: assert property (p_forced_off) else $error("output on in restart or fail-safe");

   property p_ov_off;
      (sense_sync.ov && !overvolt_shutdown_cfg) |=> (high_side_output == 4'h0);
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("output on during overvoltage");

   property p_uv_off;
      (sense_sync.uv && !undervolt_shutdown_cfg) |=> (high_side_output == 4'h0);
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("output on during undervoltage");

   property p_no_recover;
      supply_clear |=> (cfg[0] == SRC_OFF && cfg[1] == SRC_OFF
                        && cfg[2] == SRC_OFF && cfg[3] == SRC_OFF);
   endproperty
   a_no_recover: assert property (p_no_recover) else $error("fields kept without recovery");

   property p_oc_shutdown;
      oc_trip[0] |=> (output_overcurrent_flag[0] && cfg[0] == SRC_OFF && !high_side_output[0]);
   endproperty
   a_oc_shutdown: assert property (p_oc_shutdown) else $error("overcurrent shutdown missed");

   property p_oc_sticky;
      (output_overcurrent_flag[0] && !clr_oc[0]) |=> output_overcurrent_flag[0];
   endproperty
   a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent flag lost");

   property p_ol_sticky;
      (open_load_flag[0] && !clr_ol[0]) |=> open_load_flag[0];
   endproperty
   a_ol_sticky: assert property (p_ol_sticky) else $error("open-load flag lost");

   property p_ol_stays_on;
      (ol_trip[0] && !oc_trip[0] && !supply_trip && !forced_off && cfg[0] == SRC_ON)
         |=> (high_side_output[0] && open_load_flag[0]);
   endproperty
   a_ol_stays_on: assert property (p_ol_stays_on) else $error("open load switched output");

   property p_locked;
      (!cfg_open && !entering_forced && !supply_clear && !oc_trip[1]) |=> $stable(cfg[1]);
   endproperty
   a_locked: assert property (p_locked) else $error("config changed outside normal mode");

   property p_duty_zero;
      (cfg[0] == SRC_PWM1 && duty_gen[0] == 8'h00) |=> !high_side_output[0];
   endproperty
   a_duty_zero: assert property (p_duty_zero) else $error("pulse with zero duty");

   c_oc_trip:    cover property (oc_trip[0]);
   c_recover:    cover property (supply_trip && supply_fault_recovery_en ##1 !supply_trip);
   c_pwm_toggle: cover property ((cfg[1] == SRC_PWM2) && $rose(high_side_output[1]));
   c_ol_flag:    cover property ($rose(open_load_flag[0]));

endmodule

`default_nettype wire

// ### bench/hss_host_model.sv
// register master standing in for the configuring microcontroller
// assumes read data stand only in the cycle after the read strobe edge
`timescale 1ns/1ns
`default_nettype none

module hss_host_model (
   // clock
   input  wire logic        core_clk,
   // register port
   output logic      [7:0]  reg_addr,
   output logic      [31:0] reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // returns at the edge that takes the write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      // a released bus must not look like the last word
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// ### bench/test_high_side_switch_control.sv
// self-checking bench for the high-side switch control block
// assumes shortened open-load filter and pwm tick; the overcurrent filter stays full length
`timescale 1ns/1ns
`default_nettype none

module test_high_side_switch_control;
   import hss_pkg::*;
   localparam int OLC  = 20;
   localparam int TICK = 8;

   logic        core_clk;
   logic        resetn;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   mode_e       sbc_mode;
   logic        timer1;
   logic        timer2;
   sense_s      sense;
   logic [3:0]  hso;
   int          miscompares;
   int          num_checks;
   int          seed;
   logic [31:0] rv;
   logic [31:0] rnd;
   logic [7:0]  d1;
   logic [7:0]  d2;
   int          hi [3];
   int          ri [3];

   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   hss_host_model u_hss_host_model (
      .core_clk  (core_clk),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata)
   );

   high_side_switch_control #(.OL_FILTER_CYCLES(OLC), .PWM_TICK_CYCLES(TICK))
   u_high_side_switch_control (
      .core_clk         (core_clk),
      .resetn           (resetn),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .sbc_mode         (sbc_mode),
      .timer1           (timer1),
      .timer2           (timer2),
      .sense_async      (sense),
      .high_side_output (hso)
   );

   function automatic logic exp_src(input logic [2:0] c, input logic t1, input logic t2);
      case (c)
         SRC_ON:     return 1'b1;
         SRC_TIMER1: return t1;
         SRC_TIMER2: return t2;
         default:    return 1'b0;
      endcase
   endfunction

   function automatic int steps(input logic fast);
      return fast ? TICK / 2 : TICK;
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      u_hss_host_model.rd(a, rv);
      chk(what, rv, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_hss_host_model.wr(a, d);
   endtask

   task automatic done(input string n);
      $display("test %s finished, %0d checks so far", n, num_checks);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // whole run is about 25k cycles; allow close to four times that
   initial begin
      #400000;
      miscompares++;
      end_sim();
   end

   initial begin
      seed        = 32'hdeb9;
      miscompares = 0;
      num_checks  = 0;
      resetn      = 1'b0;
      sbc_mode    = MODE_NORMAL;
      timer1      = 1'b0;
      timer2      = 1'b0;
      sense       = '0;
      cyc(20);
      resetn <= 1'b1;
      cyc(2);
      wr(8'h24, 32'hffff_ffff);
      for (int a = 0; a <= 36; a += 4) rchk("reset value", 8'(a), 32'h0);
      done("reset");

      wr(OFS_CTRL_A, 32'h0000_0032);
      wr(OFS_CTRL_B, 32'h0000_0061);
      repeat (24) begin
         rnd = $random(seed);
         timer1 <= rnd[0];
         timer2 <= rnd[1];
         cyc(3);
         chk("out src", {28'h0, hso}, {28'h0, 1'b0, exp_src(3'h1, rnd[0], rnd[1]),
             exp_src(3'h3, rnd[0], rnd[1]), exp_src(3'h2, rnd[0], rnd[1])});
      end
      done("sources");

      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_CTRL_A, 32'h0000_0011);
      sbc_mode <= MODE_STOP;
      cyc(2);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_DUTY1, 32'h0000_0055);
      rchk("ctrl in stop", OFS_CTRL_A, 32'h0000_0011);
      rchk("duty in stop", OFS_DUTY1, 32'h0);
      chk("out in stop", {28'h0, hso}, 32'h3);
      foreach (ri[k]) begin
         if (k == 2) break;
         sbc_mode <= MODE_NORMAL;
         wr(OFS_CTRL_A, 32'h0000_0011);
         cyc(3);
         sbc_mode <= k ? MODE_FAILSAFE : MODE_RESTART;
         cyc(3);
         chk("out forced off", {28'h0, hso}, 32'h0);
         rchk("ctrl cleared", OFS_CTRL_A, 32'h0);
      end
      sbc_mode <= MODE_NORMAL;
      wr(OFS_CTRL_A, 32'h0000_0011);
      cyc(3);
      chk("re-enabled", {28'h0, hso}, 32'h3);
      done("modes");

      wr(OFS_SUPPLY_CFG, 32'h4);
      sense.ov <= 1'b1;
      cyc(5);
      chk("ov off", {28'h0, hso}, 32'h0);
      sense.ov <= 1'b0;
      cyc(5);
      chk("ov recover", {28'h0, hso}, 32'h3);
      rchk("ov flag", OFS_SUPPLY_ST, 32'h1);
      rchk("no oc flag", OFS_OC_STAT, 32'h0);
      rchk("no ol flag", OFS_OL_STAT, 32'h0);
      wr(OFS_SUPPLY_ST, 32'h3);
      wr(OFS_SUPPLY_CFG, 32'h0);
      sense.uv <= 1'b1;
      cyc(5);
      chk("uv off", {28'h0, hso}, 32'h0);
      sense.uv <= 1'b0;
      cyc(5);
      chk("uv stays off", {28'h0, hso}, 32'h0);
      rchk("uv clears ctrl", OFS_CTRL_A, 32'h0);
      rchk("uv flag", OFS_SUPPLY_ST, 32'h2);
      wr(OFS_SUPPLY_CFG, 32'h3);
      wr(OFS_CTRL_A, 32'h0000_0011);
      sense.ov <= 1'b1;
      sense.uv <= 1'b1;
      cyc(5);
      chk("shutdown disabled", {28'h0, hso}, 32'h3);
      sense.ov <= 1'b0;
      sense.uv <= 1'b0;
      cyc(3);
      wr(OFS_SUPPLY_ST, 32'h3);
      wr(OFS_SUPPLY_CFG, 32'h0);
      done("supply");

      sbc_mode <= MODE_SLEEP;
      cyc(2);
      // a permanently-on output outlasts the overcurrent filter
      sense.oc[0] <= 1'b1;
      cyc(3990);
      chk("oc filtering", {28'h0, hso}, 32'h3);
      cyc(20);
      chk("oc off", {28'h0, hso}, 32'h2);
      sense.oc[0] <= 1'b0;
      cyc(10);
      rchk("oc flag", OFS_OC_STAT, 32'h1);
      rchk("oc field reset", OFS_CTRL_A, 32'h0000_0010);
      wr(OFS_OC_STAT, 32'h1);
      rchk("oc flag clear", OFS_OC_STAT, 32'h0);
      sbc_mode <= MODE_NORMAL;
      // flag cleared first, then the field rewritten to on
      wr(OFS_CTRL_A, 32'h0000_0011);
      done("overcurrent");

      sense.ol <= 4'h7;
      cyc(10);
      rchk("ol filtering", OFS_OL_STAT, 32'h0);
      cyc(30);
      rchk("ol flag", OFS_OL_STAT, 32'h3);
      chk("ol stays on", {28'h0, hso}, 32'h3);
      sense.ol <= 4'h0;
      cyc(10);
      rchk("ol sticky", OFS_OL_STAT, 32'h3);
      wr(OFS_OL_STAT, 32'h1);
      rchk("ol clear one", OFS_OL_STAT, 32'h2);
      wr(OFS_OL_STAT, 32'h2);
      done("open load");

      wr(OFS_CTRL_A, 32'h0000_0054);
      wr(OFS_CTRL_B, 32'h0000_0004);
      for (int f = 0; f < 4; f++) begin
         rnd = $random(seed);
         d1 = (f == 0) ? 8'hff : rnd[7:0];
         d2 = (f == 3) ? 8'h00 : rnd[15:8];
         // a one-step pulse shows at the pin for only TICK or TICK/2 cycles; software never relies on it
         if (d1 == 8'h01) d1 = 8'h02;
         if (d2 == 8'h01) d2 = 8'h02;
         wr(OFS_DUTY1, {24'h0, d1});
         wr(OFS_DUTY2, {24'h0, d2});
         wr(OFS_FREQ, 32'(f));
         cyc(256 * TICK);
         hi = '{0, 0, 0};
         ri = '{0, 0, 0};
         rnd[2:0] = hso[2:0];
         repeat (256 * TICK) begin
            @(posedge core_clk);
            for (int k = 0; k < 3; k++) begin
               hi[k] += hso[k];
               ri[k] += (hso[k] && !rnd[k]);
               rnd[k] = hso[k];
            end
         end
         chk("pwm1 high", 32'(hi[0]), 32'(d1 * steps(f[0]) * (f[0] ? 2 : 1)));
         chk("pwm1 shared", 32'(hi[2]), 32'(hi[0]));
         chk("pwm2 high", 32'(hi[1]), 32'(d2 * steps(f[1]) * (f[1] ? 2 : 1)));
         chk("pwm1 periods", 32'(ri[0]), (d1 == 0) ? 32'h0 : (f[0] ? 32'h2 : 32'h1));
         chk("pwm2 periods", 32'(ri[1]), (d2 == 0) ? 32'h0 : (f[1] ? 32'h2 : 32'h1));
      end
      done("pwm");

      // at 200 Hz a step lasts TICK cycles against an OLC-cycle filter:
      // two steps of on-time are too short, three outlast the filter
      wr(OFS_DUTY1, 32'h0000_0002);
      wr(OFS_FREQ, 32'h0);
      sense.ol <= 4'h1;
      cyc(256 * TICK);
      rchk("ol two steps", OFS_OL_STAT, 32'h0);
      wr(OFS_DUTY1, 32'h0000_0003);
      cyc(256 * TICK);
      rchk("ol three steps", OFS_OL_STAT, 32'h1);
      sense.ol <= 4'h0;
      done("pwm open load");
      end_sim();
   end
endmodule

`default_nettype wire
